// [design/itcp_bus_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface itcp_bus_if;
	logic hostSclOut;
	logic hostSclOeN;
	logic hostSdaOut;
	logic hostSdaOeN;
	logic devSdaOut;
	logic devSdaOeN;
	logic powerDownPin;
	logic scl;
	logic sda;

	// open-drain wires with pull-up
	assign scl = hostSclOeN | hostSclOut;
	assign sda = (hostSdaOeN | hostSdaOut) & (devSdaOeN | devSdaOut);

	modport target (input scl, input sda, input powerDownPin, output devSdaOut, output devSdaOeN);
	modport controller (input scl, input sda, output hostSclOut, output hostSclOeN,
		output hostSdaOut, output hostSdaOeN, output powerDownPin);
endinterface
`default_nettype wire

// [design/itcp_controller.sv]
`timescale 1ns/100ps
`default_nettype none
module itcp_controller (
	input wire logic clk_sys,
	input wire logic resetn,
	itcp_bus_if.controller bus,
	input wire logic [2:0] cmdAddr,
	input wire logic [7:0] cmdWdata,
	input wire logic cmdWr,
	input wire logic cmdRd,
	output logic [7:0] cmdRdata
);
	itcp_pkg::itcp_hop_t op;
	logic [2:0] stage_reg;
	logic [1:0] q_reg;
	logic [7:0] qCnt_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] shift_reg;
	logic busy_reg;
	logic sclLow_reg;
	logic sdaLow_reg;
	logic fast_reg;
	logic read_reg;
	logic [6:0] tgt_reg;
	logic [7:0] regAddr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rdata_reg;
	logic nack_reg;
	logic sda;
	logic tick;
	logic goCmd;
	logic nackSet;
	logic nackClr;
	logic opEnd;

	// receiver ack sampled through the filter
	itcp_pin_filter #(
		.WIDTH(1),
		.HOLD(itcp_pkg::GLITCH_CYC),
		.INIT(1'b1)
	) u_filter (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pinIn(bus.sda),
		.pinOut(sda)
	);

	// read is address write, restart, read
	function automatic itcp_pkg::itcp_hop_t opOf(input logic rd, input logic [2:0] st);
		unique case (st)
			3'h0: opOf = itcp_pkg::H_START;
			3'h1, 3'h2: opOf = itcp_pkg::H_TX;
			3'h3: opOf = rd ? itcp_pkg::H_START : itcp_pkg::H_TX;
			3'h4: opOf = rd ? itcp_pkg::H_TX : itcp_pkg::H_STOP;
			3'h5: opOf = itcp_pkg::H_RX;
			default: opOf = itcp_pkg::H_STOP;
		endcase
	endfunction

	function automatic logic [7:0] txByte(input logic [2:0] st);
		unique case (st)
			3'h1: txByte = {tgt_reg, 1'b0};
			3'h2: txByte = regAddr_reg;
			3'h3: txByte = wdata_reg;
			default: txByte = {tgt_reg, 1'b1};
		endcase
	endfunction

	assign op = busy_reg ? opOf(read_reg, stage_reg) : itcp_pkg::H_IDLE;
	assign tick = qCnt_reg == (fast_reg ? 8'(itcp_pkg::QTR_FAST_CYC - 1) : 8'(itcp_pkg::QTR_STD_CYC - 1));
	assign goCmd = cmdWr && cmdAddr == itcp_pkg::HOST_CTRL && cmdWdata[itcp_pkg::CTRL_GO] && !busy_reg;
	assign nackSet = tick && q_reg == 2'h2 && op == itcp_pkg::H_TX && bitCnt_reg == 4'h8 && sda;
	assign nackClr = cmdWr && cmdAddr == itcp_pkg::HOST_STATUS && cmdWdata[itcp_pkg::STAT_NACK];
	assign opEnd = tick && q_reg == 2'h3 && (op == itcp_pkg::H_START || op == itcp_pkg::H_STOP || bitCnt_reg == 4'h8);

	// scl made by divider, sda moved in quarter 0 while scl low, start/stop edges in quarter 2 with scl high
	assign bus.hostSclOut = 1'b0;
	assign bus.hostSclOeN = ~sclLow_reg;
	assign bus.hostSdaOut = 1'b0;
	assign bus.hostSdaOeN = ~sdaLow_reg;
	assign bus.powerDownPin = 1'b1;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fast_reg <= 1'b0;
			read_reg <= 1'b0;
			tgt_reg <= 7'h00;
			regAddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			nack_reg <= 1'b0;
			cmdRdata <= 8'h00;
		end else begin
			if (cmdWr && !busy_reg) begin
				unique case (cmdAddr)
					itcp_pkg::HOST_CTRL: begin
						fast_reg <= cmdWdata[itcp_pkg::CTRL_FAST];
						read_reg <= cmdWdata[itcp_pkg::CTRL_READ];
					end
					itcp_pkg::HOST_TARGET: tgt_reg <= cmdWdata[6:0];
					itcp_pkg::HOST_REGADDR: regAddr_reg <= cmdWdata;
					itcp_pkg::HOST_WDATA: wdata_reg <= cmdWdata;
					default: tgt_reg <= tgt_reg;
				endcase
			end
			// set wins over clear
			nack_reg <= nackSet | (nack_reg & ~nackClr);
			if (cmdRd) begin
				unique case (cmdAddr)
					itcp_pkg::HOST_CTRL: cmdRdata <= {5'h00, fast_reg, read_reg, 1'b0};
					itcp_pkg::HOST_TARGET: cmdRdata <= {1'b0, tgt_reg};
					itcp_pkg::HOST_REGADDR: cmdRdata <= regAddr_reg;
					itcp_pkg::HOST_WDATA: cmdRdata <= wdata_reg;
					itcp_pkg::HOST_RDATA: cmdRdata <= rdata_reg;
					itcp_pkg::HOST_STATUS: cmdRdata <= {6'h00, nack_reg, busy_reg};
					default: cmdRdata <= 8'h00;
				endcase
			end else begin
				cmdRdata <= 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			busy_reg <= 1'b0;
			stage_reg <= 3'h0;
			q_reg <= 2'h0;
			qCnt_reg <= 8'h00;
			bitCnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			rdata_reg <= 8'h00;
			sclLow_reg <= 1'b0;
			sdaLow_reg <= 1'b0;
		end else if (goCmd) begin
			busy_reg <= 1'b1;
			stage_reg <= 3'h0;
			q_reg <= 2'h0;
			qCnt_reg <= 8'h00;
			bitCnt_reg <= 4'h0;
		end else if (busy_reg) begin
			qCnt_reg <= tick ? 8'h00 : qCnt_reg + 8'h01;
			if (tick) begin
				q_reg <= q_reg + 2'h1;
				unique case (q_reg)
					2'h0: begin
						// start and stop set up in quarter 0
						unique case (op)
							itcp_pkg::H_START: sdaLow_reg <= 1'b0;
							itcp_pkg::H_STOP: sdaLow_reg <= 1'b1;
							// msb first, ninth bit released for the ack
							itcp_pkg::H_TX: sdaLow_reg <= bitCnt_reg != 4'h8 && !shift_reg[7];
							// last read byte answered with nack
							default: sdaLow_reg <= 1'b0;
						endcase
					end
					2'h1: sclLow_reg <= 1'b0;
					2'h2: begin
						if (op == itcp_pkg::H_START) begin
							sdaLow_reg <= 1'b1;
						end else if (op == itcp_pkg::H_STOP) begin
							sdaLow_reg <= 1'b0;
						end else if (op == itcp_pkg::H_RX && bitCnt_reg != 4'h8) begin
							shift_reg <= {shift_reg[6:0], sda};
						end
					end
					default: begin
						if (op == itcp_pkg::H_STOP) begin
							busy_reg <= 1'b0;
						end else begin
							sclLow_reg <= 1'b1;
						end
						if (op == itcp_pkg::H_TX && bitCnt_reg != 4'h8) begin
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
						bitCnt_reg <= opEnd ? 4'h0 : bitCnt_reg + 4'h1;
						if (op == itcp_pkg::H_RX && opEnd) begin
							rdata_reg <= shift_reg;
						end
						if (opEnd && op != itcp_pkg::H_STOP) begin
							if (nack_reg && op == itcp_pkg::H_TX) begin
								stage_reg <= read_reg ? itcp_pkg::STOP_STAGE_RD : itcp_pkg::STOP_STAGE_WR;
							end else begin
								stage_reg <= stage_reg + 3'h1;
								shift_reg <= txByte(stage_reg + 3'h1);
							end
						end
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [design/itcp_pin_filter.sv]
`timescale 1ns/100ps
`default_nettype none
module itcp_pin_filter #(
	parameter int WIDTH = 2,
	parameter int HOLD = itcp_pkg::GLITCH_CYC,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] out_reg;
	logic [7:0] cnt_reg [WIDTH];

	assign pinOut = out_reg;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			out_reg <= INIT;
			for (int i = 0; i < WIDTH; i++) begin
				cnt_reg[i] <= 8'h00;
			end
		end else begin
			s1_reg <= pinIn;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// a new level must stand for HOLD+1 samples, shorter pulses vanish
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_reg[i] == s3_reg[i] && s3_reg[i] != out_reg[i]) begin
					if (cnt_reg[i] == 8'(HOLD - 1)) begin
						out_reg[i] <= s3_reg[i];
						cnt_reg[i] <= 8'h00;
					end else begin
						cnt_reg[i] <= cnt_reg[i] + 8'h01;
					end
				end else begin
					cnt_reg[i] <= 8'h00;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [design/itcp_pkg.sv]
`default_nettype none
package itcp_pkg;
	// system clock and link timing
	localparam int SYS_CLK_MHZ = 50;
	localparam int SCL_STD_PERIOD_NS = 10000;
	localparam int SCL_FAST_PERIOD_NS = 2500;
	localparam int GLITCH_NS = 50;
	// least times round up to whole cycles
	localparam int GLITCH_CYC = (GLITCH_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int QTR_STD_CYC = (SCL_STD_PERIOD_NS * SYS_CLK_MHZ + 3999) / 4000;
	localparam int QTR_FAST_CYC = (SCL_FAST_PERIOD_NS * SYS_CLK_MHZ + 3999) / 4000;
	localparam int STRAP_SETTLE_CYC = 16;

	// target address and register map
	localparam logic [4:0] ADDR_UPPER_DEF = 5'h19;
	localparam int NV_ADDR_BYTE = 11;
	localparam logic [7:0] REG_ADDR_READBACK = 8'h0A;
	localparam logic [7:0] NV_FILL_DEF = 8'h00;

	// three-level address-select pin codes and the low address bits they give
	localparam logic [1:0] SEL_LOW = 2'h0;
	localparam logic [1:0] SEL_MID = 2'h1;
	localparam logic [1:0] SEL_HIGH = 2'h2;
	localparam logic [1:0] LOW_BITS_LOW = 2'h0;
	localparam logic [1:0] LOW_BITS_MID = 2'h1;
	localparam logic [1:0] LOW_BITS_HIGH = 2'h3;

	// controller command registers
	localparam logic [2:0] HOST_CTRL = 3'h0;
	localparam logic [2:0] HOST_TARGET = 3'h1;
	localparam logic [2:0] HOST_REGADDR = 3'h2;
	localparam logic [2:0] HOST_WDATA = 3'h3;
	localparam logic [2:0] HOST_RDATA = 3'h4;
	localparam logic [2:0] HOST_STATUS = 3'h5;
	localparam int CTRL_GO = 0;
	localparam int CTRL_READ = 1;
	localparam int CTRL_FAST = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam logic [2:0] STOP_STAGE_WR = 3'h4;
	localparam logic [2:0] STOP_STAGE_RD = 3'h6;

	typedef enum logic [2:0] {T_IDLE, T_RECV, T_ACK, T_SEND, T_RACK, T_PREP, T_IGNORE} itcp_tstate_t;
	typedef enum logic [1:0] {K_DEV, K_REG, K_DATA} itcp_kind_t;
	typedef enum logic [1:0] {L_SETTLE, L_COPY, L_DONE} itcp_lstate_t;
	typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} itcp_hop_t;
endpackage
`default_nettype wire

// [design/itcp_target.sv]
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - works at 100 kHz and 400 kHz
// - pulses under 50 ns are ignored
// - respond only to own 7-bit address
// - address is nv upper five plus strap
// - strap low/mid/high gives 0/1/3
// - readback reports address, upper bits nv only
// - host holds power-down high, repeats first
// - data changes only while clock low
// - start/stop by controller, sda edge, scl high
// - eight bits, msb first, then acknowledge
// - receiver acks low, nacks released high
// - ack address match only, else stay silent
// - read ends on nack, target goes idle
// - write stop follows last acknowledge
// - byte registers picked by register address
// - read-only writes accepted, value unchanged
// - host leaves reserved bits at default
// - power-up copy from rom or eeprom
// - host limits eeprom rewrites, rom fixed
// - register address increments per byte
// - read is address write then restart
module itcp_target #(
	parameter int DEPTH = 256,
	parameter logic [7:0] EE_FILL = itcp_pkg::NV_FILL_DEF,
	parameter logic [7:0] ROM_FILL = itcp_pkg::NV_FILL_DEF,
	parameter logic [4:0] EE_ADDR_UPPER = itcp_pkg::ADDR_UPPER_DEF,
	parameter logic [4:0] ROM_ADDR_UPPER = itcp_pkg::ADDR_UPPER_DEF
) (
	input wire logic clk_sys,
	input wire logic resetn,
	itcp_bus_if.target bus,
	input wire logic [1:0] addressSelectPin,
	input wire logic controlSourceSelectPin,
	output logic loadDone,
	output logic [6:0] targetAddress,
	output logic cfgWrStrobe,
	output logic [7:0] cfgWrAddr,
	output logic [7:0] cfgWrData
);
	localparam int AW = $clog2(DEPTH);

	////////////////////////////////////////////////////////////////
	// pin sampling

	logic [5:0] pinsFilt;
	logic scl;
	logic sda;
	logic powerUp;
	logic srcEe;
	logic [1:0] addrSel;

	itcp_pin_filter #(
		.WIDTH(6),
		.HOLD(itcp_pkg::GLITCH_CYC),
		.INIT(6'h3F)
	) u_filter (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pinIn({bus.powerDownPin, controlSourceSelectPin, addressSelectPin, bus.scl, bus.sda}),
		.pinOut(pinsFilt)
	);

	assign powerUp = pinsFilt[5];
	assign srcEe = pinsFilt[4];
	assign addrSel = pinsFilt[3:2];
	assign scl = pinsFilt[1];
	assign sda = pinsFilt[0];

	////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [1:0] lowBits(input logic [1:0] sel);
		unique case (sel)
			itcp_pkg::SEL_MID: lowBits = itcp_pkg::LOW_BITS_MID;
			itcp_pkg::SEL_HIGH: lowBits = itcp_pkg::LOW_BITS_HIGH;
			default: lowBits = itcp_pkg::LOW_BITS_LOW;
		endcase
	endfunction

	function automatic logic [7:0] nvImage(input logic fromEe, input logic [AW-1:0] a);
		if (a == AW'(itcp_pkg::NV_ADDR_BYTE)) begin
			nvImage = fromEe ? {EE_ADDR_UPPER, 3'h0} : {ROM_ADDR_UPPER, 3'h0};
		end else begin
			nvImage = fromEe ? EE_FILL : ROM_FILL;
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// power-up load

	itcp_pkg::itcp_lstate_t load_reg;
	logic [AW-1:0] idx_reg;
	logic srcEe_reg;
	logic [4:0] addrUpper_reg;
	logic [1:0] addrLow_reg;
	logic [7:0] mem [DEPTH];
	logic [7:0] img;
	logic loadWe;

	assign img = nvImage(srcEe_reg, idx_reg);
	assign loadWe = load_reg == itcp_pkg::L_COPY;
	assign loadDone = load_reg == itcp_pkg::L_DONE;
	assign targetAddress = {addrUpper_reg, addrLow_reg};

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			load_reg <= itcp_pkg::L_SETTLE;
			idx_reg <= '0;
			srcEe_reg <= 1'b0;
			addrUpper_reg <= itcp_pkg::ADDR_UPPER_DEF;
			addrLow_reg <= itcp_pkg::LOW_BITS_LOW;
		end else begin
			unique case (load_reg)
				itcp_pkg::L_SETTLE: begin
					idx_reg <= idx_reg + AW'(1);
					// straps caught once, after the synchronisers settle
					if (idx_reg == AW'(itcp_pkg::STRAP_SETTLE_CYC - 1)) begin
						srcEe_reg <= srcEe;
						addrLow_reg <= lowBits(addrSel);
						idx_reg <= '0;
						load_reg <= itcp_pkg::L_COPY;
					end
				end
				itcp_pkg::L_COPY: begin
					idx_reg <= idx_reg + AW'(1);
					// upper address bits change only from nv byte
					if (idx_reg == AW'(itcp_pkg::NV_ADDR_BYTE)) begin
						addrUpper_reg <= img[7:3];
					end
					if (idx_reg == AW'(DEPTH - 1)) begin
						load_reg <= itcp_pkg::L_DONE;
					end
				end
				itcp_pkg::L_DONE: begin
					load_reg <= itcp_pkg::L_DONE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// bus events

	logic sclPrev_reg;
	logic sdaPrev_reg;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	assign sclRise = scl & ~sclPrev_reg;
	assign sclFall = ~scl & sclPrev_reg;
	assign startCond = scl & sclPrev_reg & sdaPrev_reg & ~sda;
	assign stopCond = scl & sclPrev_reg & ~sdaPrev_reg & sda;

	////////////////////////////////////////////////////////////////
	// byte engine

	itcp_pkg::itcp_tstate_t state_reg;
	itcp_pkg::itcp_kind_t kind_reg;
	logic [7:0] shift_reg;
	logic [3:0] bitCnt_reg;
	logic [AW-1:0] ptr_reg;
	logic readMode_reg;
	logic drvLow_reg;
	logic [7:0] readByte;
	logic isReadback;
	logic busWe;
	logic byteDone;
	logic addrMatch;

	assign isReadback = ptr_reg == AW'(itcp_pkg::REG_ADDR_READBACK);
	assign readByte = isReadback ? {targetAddress, 1'b0} : mem[ptr_reg];
	assign byteDone = state_reg == itcp_pkg::T_RECV && sclFall && bitCnt_reg == 4'h8;
	assign addrMatch = shift_reg[7:1] == targetAddress;
	assign busWe = byteDone && kind_reg == itcp_pkg::K_DATA && !isReadback;

	assign bus.devSdaOut = 1'b0;
	assign bus.devSdaOeN = ~drvLow_reg;

	always_ff @(posedge clk_sys) begin
		if (loadWe) begin
			mem[idx_reg] <= img;
		end else if (busWe) begin
			mem[ptr_reg] <= shift_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			state_reg <= itcp_pkg::T_IDLE;
			kind_reg <= itcp_pkg::K_DEV;
			shift_reg <= 8'h00;
			bitCnt_reg <= 4'h0;
			ptr_reg <= '0;
			readMode_reg <= 1'b0;
			drvLow_reg <= 1'b0;
			cfgWrStrobe <= 1'b0;
			cfgWrAddr <= 8'h00;
			cfgWrData <= 8'h00;
		end else begin
			sclPrev_reg <= scl;
			sdaPrev_reg <= sda;
			cfgWrStrobe <= busWe;
			if (busWe) begin
				cfgWrAddr <= 8'(ptr_reg);
				cfgWrData <= shift_reg;
			end
			if (!powerUp || !loadDone || stopCond) begin
				state_reg <= itcp_pkg::T_IDLE;
				drvLow_reg <= 1'b0;
			end else if (startCond) begin
				state_reg <= itcp_pkg::T_RECV;
				kind_reg <= itcp_pkg::K_DEV;
				bitCnt_reg <= 4'h0;
				drvLow_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					itcp_pkg::T_IDLE, itcp_pkg::T_IGNORE: begin
						drvLow_reg <= 1'b0;
					end
					itcp_pkg::T_RECV: begin
						if (sclRise && bitCnt_reg != 4'h8) begin
							shift_reg <= {shift_reg[6:0], sda};
							bitCnt_reg <= bitCnt_reg + 4'h1;
						end
						// ack driven after the falling edge
						if (byteDone) begin
							unique case (kind_reg)
								itcp_pkg::K_DEV: begin
									if (addrMatch) begin
										drvLow_reg <= 1'b1;
										readMode_reg <= shift_reg[0];
										state_reg <= itcp_pkg::T_ACK;
									end else begin
										state_reg <= itcp_pkg::T_IGNORE;
									end
								end
								itcp_pkg::K_REG: begin
									ptr_reg <= shift_reg[AW-1:0];
									drvLow_reg <= 1'b1;
									state_reg <= itcp_pkg::T_ACK;
								end
								default: begin
									ptr_reg <= ptr_reg + AW'(1);
									drvLow_reg <= 1'b1;
									state_reg <= itcp_pkg::T_ACK;
								end
							endcase
						end
					end
					itcp_pkg::T_ACK: begin
						// ack held through the ninth pulse
						if (sclFall) begin
							bitCnt_reg <= 4'h0;
							if (kind_reg == itcp_pkg::K_DEV && readMode_reg) begin
								shift_reg <= readByte;
								ptr_reg <= ptr_reg + AW'(1);
								drvLow_reg <= ~readByte[7];
								state_reg <= itcp_pkg::T_SEND;
							end else begin
								drvLow_reg <= 1'b0;
								kind_reg <= kind_reg == itcp_pkg::K_DEV ? itcp_pkg::K_REG : itcp_pkg::K_DATA;
								state_reg <= itcp_pkg::T_RECV;
							end
						end
					end
					itcp_pkg::T_SEND: begin
						if (sclFall) begin
							bitCnt_reg <= bitCnt_reg + 4'h1;
							if (bitCnt_reg == 4'h7) begin
								drvLow_reg <= 1'b0;
								state_reg <= itcp_pkg::T_RACK;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								drvLow_reg <= ~shift_reg[6];
							end
						end
					end
					itcp_pkg::T_RACK: begin
						// nack from the controller ends the read
						if (sclRise) begin
							state_reg <= sda ? itcp_pkg::T_IGNORE : itcp_pkg::T_PREP;
						end
					end
					itcp_pkg::T_PREP: begin
						// next byte from the following address
						if (sclFall) begin
							shift_reg <= readByte;
							ptr_reg <= ptr_reg + AW'(1);
							drvLow_reg <= ~readByte[7];
							bitCnt_reg <= 4'h0;
							state_reg <= itcp_pkg::T_SEND;
						end
					end
					default: begin
						state_reg <= itcp_pkg::T_IDLE;
						drvLow_reg <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [test/i2c_target_config_port_test.sv]
`timescale 1ns/100ps
`default_nettype none
module i2c_target_config_port_test;
	localparam logic [4:0] EE_UP = 5'h0B;
	localparam logic [7:0] EE_FILL_T = 8'h5A;
	localparam logic [7:0] ROM_FILL_T = 8'hA5;
	localparam logic [1:0] LOW_OF [4] = '{itcp_pkg::LOW_BITS_LOW, itcp_pkg::LOW_BITS_MID, itcp_pkg::LOW_BITS_HIGH, itcp_pkg::LOW_BITS_LOW};
	logic clk_sys;
	logic resetn;
	logic [1:0] addressSelectPin;
	logic controlSourceSelectPin;
	logic loadDone;
	logic [6:0] targetAddress;
	logic cfgWrStrobe;
	logic [7:0] cfgWrAddr;
	logic [7:0] cfgWrData;
	logic [2:0] cmdAddr;
	logic [7:0] cmdWdata;
	logic cmdWr;
	logic cmdRd;
	logic [7:0] cmdRdata;
	logic [6:0] expAddr;
	logic [7:0] st;
	logic [7:0] rv;
	logic [7:0] lastA;
	logic [7:0] lastD;
	int err_count;
	int checked;
	int wrCount;
	int base;
	itcp_bus_if busIf();
	itcp_target #(.EE_FILL(EE_FILL_T), .ROM_FILL(ROM_FILL_T), .EE_ADDR_UPPER(EE_UP)) itcp_target_inst (.clk_sys(clk_sys),
		.resetn(resetn), .bus(busIf.target), .addressSelectPin(addressSelectPin),
		.controlSourceSelectPin(controlSourceSelectPin), .loadDone(loadDone), .targetAddress(targetAddress),
		.cfgWrStrobe(cfgWrStrobe), .cfgWrAddr(cfgWrAddr), .cfgWrData(cfgWrData));
	itcp_controller itcp_controller_inst (.clk_sys(clk_sys), .resetn(resetn), .bus(busIf.controller),
		.cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata));
	itcp_sva itcp_sva_inst (.clk_sys(clk_sys), .resetn(resetn), .hostSclOut(busIf.hostSclOut),
		.hostSclOeN(busIf.hostSclOeN), .hostSdaOut(busIf.hostSdaOut), .hostSdaOeN(busIf.hostSdaOeN),
		.devSdaOut(busIf.devSdaOut), .devSdaOeN(busIf.devSdaOeN), .powerDownPin(busIf.powerDownPin),
		.scl(busIf.scl), .sda(busIf.sda), .ownAddr(expAddr));
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cmdW(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cmdAddr <= a;
		cmdWdata <= d;
		cmdWr <= 1'h1;
		@(posedge clk_sys);
		cmdWr <= 1'h0;
	endtask
	task automatic cmdR(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		cmdAddr <= a;
		cmdRd <= 1'h1;
		@(posedge clk_sys);
		cmdRd <= 1'h0;
		@(negedge clk_sys);
		d = cmdRdata;
	endtask
	// one link transfer, then wait for busy to drop
	task automatic xfer(input logic rd, input logic fast, input logic [6:0] tgt, input logic [7:0] ra,
		input logic [7:0] wd);
		int n;
		cmdW(itcp_pkg::HOST_TARGET, {1'h0, tgt});
		cmdW(itcp_pkg::HOST_REGADDR, ra);
		cmdW(itcp_pkg::HOST_WDATA, wd);
		cmdW(itcp_pkg::HOST_CTRL, {5'h00, fast, rd, 1'h1});
		repeat (2) @(posedge clk_sys);
		n = 0;
		st = 8'h01;
		while (st[itcp_pkg::STAT_BUSY] !== 1'h0 && n < 20000) begin
			cmdR(itcp_pkg::HOST_STATUS, st);
			n++;
		end
		check("busy", {7'h00, st[itcp_pkg::STAT_BUSY]}, 8'h00);
		cmdR(itcp_pkg::HOST_RDATA, rv);
	endtask
	task automatic boot(input logic src, input logic [1:0] sel, input logic [6:0] exp);
		int n;
		@(posedge clk_sys);
		resetn <= 1'h0;
		controlSourceSelectPin <= src;
		addressSelectPin <= sel;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'h1;
		expAddr = exp;
		n = 0;
		while (loadDone !== 1'h1 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		check("loadDone", {7'h00, loadDone}, 8'h01);
		check("targetAddress", {1'h0, targetAddress}, {1'h0, exp});
	endtask
	always @(posedge clk_sys) begin
		if (cfgWrStrobe === 1'h1) begin
			wrCount++;
			lastA = cfgWrAddr;
			lastD = cfgWrData;
		end
	end
	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (95000) @(posedge clk_sys);
		err_count++;
		$display("unexpected timeout: expected %h seen %h", 1'h0, 1'h1);
		end_of_test();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'h0;
		addressSelectPin = 2'h0;
		controlSourceSelectPin = 1'h0;
		cmdAddr = 3'h0;
		cmdWdata = 8'h00;
		cmdWr = 1'h0;
		cmdRd = 1'h0;
		expAddr = 7'h00;
		err_count = 0;
		checked = 0;
		wrCount = 0;
		for (int i = 0; i < 4; i++) begin
			boot(1'h0, 2'(i), {itcp_pkg::ADDR_UPPER_DEF, LOW_OF[i]});
			xfer(1'h1, 1'h1, expAddr, itcp_pkg::REG_ADDR_READBACK, 8'h00);
			check("readback", rv, {expAddr, 1'h0});
			check("status", {6'h00, st[1:0]}, 8'h00);
		end
		xfer(1'h1, 1'h1, expAddr, 8'h20, 8'h00);
		check("rom image", rv, ROM_FILL_T);
		$display("test straps done");
		boot(1'h1, itcp_pkg::SEL_MID, {EE_UP, itcp_pkg::LOW_BITS_MID});
		xfer(1'h1, 1'h1, expAddr, 8'h20, 8'h00);
		check("eeprom image", rv, EE_FILL_T);
		$display("test source done");
		base = wrCount;
		xfer(1'h0, 1'h1, expAddr, 8'h05, 8'h3C);
		check("write addr", lastA, 8'h05);
		check("write data", lastD, 8'h3C);
		xfer(1'h0, 1'h0, expAddr, 8'h06, 8'hC3);
		check("std write", lastD, 8'hC3);
		xfer(1'h0, 1'h1, expAddr, itcp_pkg::REG_ADDR_READBACK, 8'hFF);
		check("ro status", {6'h00, st[1:0]}, 8'h00);
		check("write count", 8'(wrCount - base), 8'h02);
		xfer(1'h1, 1'h1, expAddr, itcp_pkg::REG_ADDR_READBACK, 8'h00);
		check("ro value", rv, {expAddr, 1'h0});
		xfer(1'h1, 1'h1, expAddr, 8'h05, 8'h00);
		check("read back", rv, 8'h3C);
		$display("test writes done");
		xfer(1'h0, 1'h1, expAddr ^ 7'h01, 8'h06, 8'h00);
		check("nack", {6'h00, st[1:0]}, 8'h02);
		check("no store", 8'(wrCount - base), 8'h02);
		cmdR(itcp_pkg::HOST_TARGET, rv);
		check("target reg", {1'h0, rv[6:0]}, {1'h0, expAddr ^ 7'h01});
		cmdW(itcp_pkg::HOST_STATUS, 8'h02);
		cmdR(itcp_pkg::HOST_STATUS, rv);
		check("nack clear", {6'h00, rv[1:0]}, 8'h00);
		cmdR(3'h7, rv);
		check("unmapped", rv, 8'h00);
		xfer(1'h1, 1'h1, expAddr, 8'h06, 8'h00);
		check("after nack", rv, 8'hC3);
		$display("test foreign done");
		end_of_test();
	end
endmodule
`default_nettype wire

// [test/itcp_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module itcp_sva (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic hostSclOut,
	input wire logic hostSclOeN,
	input wire logic hostSdaOut,
	input wire logic hostSdaOeN,
	input wire logic devSdaOut,
	input wire logic devSdaOeN,
	input wire logic powerDownPin,
	input wire logic scl,
	input wire logic sda,
	input wire logic [6:0] ownAddr
);
	localparam int QF = 2 * itcp_pkg::QTR_FAST_CYC;
	localparam int QS = 2 * itcp_pkg::QTR_STD_CYC;
	logic sclD_reg;
	logic sdaD_reg;
	logic [4:0] bitCnt_reg;
	logic [7:0] shift_reg;
	logic [8:0] hiCnt_reg;
	wire logic sclRise;
	wire logic startEv;
	wire logic stopEv;
	wire logic [4:0] bitCnt_next;
	wire logic [7:0] shift_next;
	wire logic [8:0] hiCnt_next;
	assign sclRise = scl & ~sclD_reg;
	assign startEv = scl & sclD_reg & sdaD_reg & ~sda;
	assign stopEv = scl & sclD_reg & ~sdaD_reg & sda;
	// bits clocked since the last start, saturating
	assign bitCnt_next = startEv ? 5'h00 : (sclRise && bitCnt_reg != 5'h1F) ? bitCnt_reg + 5'h01 : bitCnt_reg;
	assign shift_next = (sclRise && bitCnt_reg < 5'h08) ? {shift_reg[6:0], sda} : shift_reg;
	assign hiCnt_next = !scl ? 9'h000 : (hiCnt_reg == 9'h1FF) ? hiCnt_reg : hiCnt_reg + 9'h001;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sclD_reg <= 1'h1;
			sdaD_reg <= 1'h1;
			bitCnt_reg <= 5'h00;
			shift_reg <= 8'h00;
			hiCnt_reg <= 9'h000;
		end else begin
			sclD_reg <= scl;
			sdaD_reg <= sda;
			bitCnt_reg <= bitCnt_next;
			shift_reg <= shift_next;
			hiCnt_reg <= hiCnt_next;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	// open drain
	a_open_drain: assert property (!devSdaOut && !hostSdaOut && !hostSclOut)
		else $error("open drain output driven high");
	a_dev_quiet: assert property (!$stable(devSdaOeN) |-> !scl && !sclD_reg)
		else $error("target data changed while clock high");
	a_host_quiet: assert property (!$stable(hostSdaOeN) && scl |-> startEv || stopEv)
		else $error("controller data changed while clock high");
	a_start_host: assert property (startEv |-> !hostSdaOeN && devSdaOeN)
		else $error("start not made by controller");
	a_addr_silent: assert property (sclRise && bitCnt_reg < 5'h08 |-> devSdaOeN)
		else $error("target drove data in address byte");
	a_ack_match: assert property (sclRise && bitCnt_reg == 5'h08 && powerDownPin |-> devSdaOeN == (shift_reg[7:1] != ownAddr))
		else $error("address acknowledge wrong");
	a_ack_hold: assert property (sclRise && !devSdaOeN |=> !devSdaOeN [*8])
		else $error("target released data during clock high");
	a_stop_release: assert property (stopEv |=> devSdaOeN [*8])
		else $error("target drives data after stop");
	a_frame_bits: assert property (stopEv |-> bitCnt_reg inside {5'h0A, 5'h13, 5'h1C})
		else $error("stop after wrong number of clocks");
	a_scl_high: assert property (sclD_reg && !scl && bitCnt_reg != 5'h00 |-> hiCnt_reg inside {[QF-4:QF+4], [QS-4:QS+4]})
		else $error("clock high time out of range");
endmodule
`default_nettype wire
